/* File: eeprom_fe_pkg.sv */
// Shared constants, states and helpers for the two-wire client front end.
// Assumes a 20 MHz core clock; bus-side logic runs on the serial clock pin.
package eeprom_fe_pkg;

  localparam logic [3:0] TYPE_CODE = 4'ha;
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 8;
  localparam int BYTE_W = 5;
  localparam int HI_W = 5;
  localparam int HI_LSB = 8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h0;

  // Internal write cycle time and the core clock rate
  localparam int T_WR_MS = 5;
  localparam int CLK_HZ = 20000000;
  localparam int WR_CYCLES_DEF = T_WR_MS * (CLK_HZ / 1000);
  localparam int WR_CNT_W = 17;

  // Toggle and pending-level bundle positions crossing into the core clock
  localparam int EV_START = 5;
  localparam int EV_STOP = 4;
  localparam int EV_ADDR = 3;
  localparam int EV_DATA = 2;
  localparam int EV_READ = 1;
  localparam int EV_PEND = 0;
  localparam int EV_W = 6;

  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_WHI, ST_WLO, ST_WDATA, ST_READ} link_st_e;

  function automatic logic addr_match(input logic [7:0] b, input logic [2:0] pins);
    addr_match = (b[7:4] == TYPE_CODE) && (b[3:1] == pins);
  endfunction : addr_match

endpackage : eeprom_fe_pkg

/* File: sync3.sv */
// Three-stage synchroniser for a bundle of independent level bits.
// Assumes each bit changes rarely compared with the receiving clock.
`timescale 1ns/1ps
module sync3
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A bit moves only once the second and third stages agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= (s2_r & s3_r) | (q & (s2_r | s3_r));
  end

endmodule : sync3

/* File: cond_detect.sv */
// Start and stop condition detector, clocked by the data line itself.
// Assumes the serial clock is steady high whenever data changes for a condition.
`timescale 1ns/1ps
module cond_detect
(
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic start_tgl,
  output logic stop_tgl
);

  // Each condition flips a toggle; receivers compare against their own copy
  always_ff @(negedge sda_i or posedge rst)
  begin
    if (rst)
      start_tgl <= 1'b0;
    else if (scl_i)
      start_tgl <= ~start_tgl; // see R5
  end

  always_ff @(posedge sda_i or posedge rst)
  begin
    if (rst)
      stop_tgl <= 1'b0;
    else if (scl_i)
      stop_tgl <= ~stop_tgl; // see R6
  end

endmodule : cond_detect

/* File: eeprom_two_wire_client_front_end.sv */
// Two-wire client front end: bus framing, address match, word address capture.
// Assumes the host owns the serial clock and the array side holds rd_byte steady.
//
// How it works
// R1: Sample data on serial clock rise; change own data only after falls.
// R2: Each byte takes nine clocks: eight data bits, then one acknowledge.
// R3: Bytes travel most significant bit first in both directions.
// R4: The driver changes data only while clock is low, steady while high.
// R5: Data falling while clock high is a start and begins a sequence.
// R6: Data rising while clock high is a stop and ends the sequence.
// R7: Keep watching the lines, but never drive or act before a start.
// R8: A repeated start accepts a fresh device address byte directly.
// R9: Transmitter releases data at the eighth fall; receiver acks low in ninth.
// R10: Host high in ninth clock while we transmit is a nack; release data.
// R11: Receiver releases data at the end of the ninth clock.
// R12: After stop return to standby unless an internal write is launched.
// R13: Enter standby when the internal write cycle completes.
// R14: Bus counts as idle only while both lines are high.
// R15: Release data within nine recovery clocks so the host can restart.
// R16: Device address upper nibble must equal the fixed type code.
// R17: Device address bits three to one must match the select pins.
// R18: Device address bit zero chooses read when one, write when zero.
// R19: Ack a matching device address byte, nack one that does not match.
// R20: Two word address bytes follow the device address, forming 13 bits.
// R21: First word byte bits four to zero become address bits twelve to eight.
// R22: Second word byte becomes address bits seven to zero, then ack.
// R23: Array is 256 pages of 32 bytes; low five bits pick the byte.
// R24: Withhold ack of device addresses while an internal write runs.
// R25: Synchronise and filter pins before use in a faster clock domain.
`timescale 1ns/1ps
module eeprom_two_wire_client_front_end
  import eeprom_fe_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic client_select_pin_0,
  input wire logic client_select_pin_1,
  input wire logic client_select_pin_2,
  input wire logic [7:0] rd_byte,
  output logic [ADDR_W-1:0] word_addr,
  output logic [PAGE_W-1:0] page_idx,
  output logic [BYTE_W-1:0] byte_idx,
  output logic addr_valid,
  output logic [7:0] wr_data,
  output logic wr_data_valid,
  output logic read_start,
  output logic write_busy,
  output logic standby
);

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock domain

  logic start_tgl;
  logic stop_tgl;
  logic start_seen_r;
  logic new_start;
  logic stop_seen_r;
  logic new_stop;
  logic [3:0] bit_cnt_r;
  link_st_e st_r;
  link_st_e st_nxt;
  logic [7:0] rx_sh_r;
  logic [7:0] tx_sh_r;
  logic host_nack_r;
  logic sda_oe_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [7:0] wdata_r;
  logic addr_tgl_r;
  logic data_tgl_r;
  logic read_tgl_r;
  logic pend_r;
  logic [3:0] link_s;
  logic busy_s;
  logic [2:0] pins_s;
  logic dev_ok;
  logic busy_r;

  cond_detect u_cond
  (
    .rst(rst),
    .scl_i(scl_clk),
    .sda_i(sda_i),
    .start_tgl(start_tgl),
    .stop_tgl(stop_tgl)
  );

  // Pins and the write-busy level reach the bus logic through three stages
  sync3 #(.W(4)) u_sync_link
  (
    .clk(scl_clk),
    .rst(rst),
    .d({busy_r, client_select_pin_2, client_select_pin_1, client_select_pin_0}),
    .q(link_s)
  ); // see R25

  assign busy_s = link_s[3];
  assign pins_s = link_s[2:0];

  // Start toggle is read directly: start hold time keeps it settled by the fall
  assign new_start = start_tgl ^ start_seen_r;
  // Stop toggle flips while the clock is high, well before the next fall
  assign new_stop = stop_tgl ^ stop_seen_r;
  assign dev_ok = addr_match(rx_sh_r, pins_s) && !busy_s; // see R16, R17, R24

  // Receive shift on rising clock, most significant bit first
  always_ff @(posedge scl_clk or posedge rst)
  begin
    if (rst)
      rx_sh_r <= 8'h00;
    else if (bit_cnt_r != BIT_ACK)
      rx_sh_r <= {rx_sh_r[6:0], sda_i}; // see R1, R3
  end

  // Host answer in the ninth clock while we transmit
  always_ff @(posedge scl_clk or posedge rst)
  begin
    if (rst)
      host_nack_r <= 1'b0;
    else if (bit_cnt_r == BIT_ACK)
      host_nack_r <= sda_i; // see R10
  end

  always_comb
  begin
    st_nxt = st_r;
    if (bit_cnt_r == BIT_LAST)
    begin
      unique case (st_r)
        ST_DEV: st_nxt = dev_ok ? (rx_sh_r[0] ? ST_READ : ST_WHI) : ST_IDLE; // see R18, R19
        ST_WHI: st_nxt = ST_WLO; // see R20
        ST_WLO: st_nxt = ST_WDATA;
        ST_IDLE, ST_WDATA, ST_READ: st_nxt = st_r;
      endcase
    end
    else if (bit_cnt_r == BIT_ACK && st_r == ST_READ && host_nack_r)
      st_nxt = ST_IDLE; // see R10
  end

  // Framing and bit count; a start wins in any state
  always_ff @(negedge scl_clk or posedge rst)
  begin
    if (rst)
    begin
      start_seen_r <= 1'b0;
      stop_seen_r <= 1'b0;
      bit_cnt_r <= BIT_FIRST;
      st_r <= ST_IDLE;
    end
    else if (new_start)
    begin
      start_seen_r <= start_tgl;
      stop_seen_r <= stop_tgl;
      bit_cnt_r <= BIT_FIRST;
      st_r <= ST_DEV; // see R5, R8
    end
    else if (new_stop)
    begin
      stop_seen_r <= stop_tgl;
      st_r <= ST_IDLE; // see R6, R7, R12
    end
    else if (st_r != ST_IDLE)
    begin
      bit_cnt_r <= (bit_cnt_r == BIT_ACK) ? BIT_FIRST : bit_cnt_r + 4'h1; // see R2
      st_r <= st_nxt;
    end
  end

  // Transmit shift register for read bytes
  always_ff @(negedge scl_clk or posedge rst)
  begin
    if (rst)
      tx_sh_r <= 8'h00;
    else if (st_r == ST_READ && bit_cnt_r == BIT_ACK)
      tx_sh_r <= rd_byte;
    else if (st_r == ST_READ && bit_cnt_r < 4'h6)
      tx_sh_r <= {tx_sh_r[6:0], 1'b0}; // see R3
  end

  // Data line drive changes only on falling clock, so it is steady while high
  always_ff @(negedge scl_clk or posedge rst)
  begin
    if (rst)
      sda_oe_r <= 1'b0;
    else if (new_start || new_stop || st_r == ST_IDLE)
      sda_oe_r <= 1'b0; // see R7, R4, R6
    else if (bit_cnt_r == BIT_LAST)
    begin
      if (st_r == ST_READ)
        sda_oe_r <= 1'b0; // see R9
      else
        sda_oe_r <= (st_r != ST_DEV) || dev_ok; // see R19, R21, R22, R24
    end
    else if (bit_cnt_r == BIT_ACK)
    begin
      if (st_nxt == ST_READ)
        sda_oe_r <= ~rd_byte[7]; // see R1, R3
      else
        sda_oe_r <= 1'b0; // see R10, R11, R15
    end
    else if (st_r == ST_READ)
      sda_oe_r <= ~tx_sh_r[6];
  end

  // Captures at the end of each received byte
  always_ff @(negedge scl_clk or posedge rst)
  begin
    if (rst)
    begin
      waddr_r <= '0;
      wdata_r <= 8'h00;
      addr_tgl_r <= 1'b0;
      data_tgl_r <= 1'b0;
      read_tgl_r <= 1'b0;
      pend_r <= 1'b0;
    end
    else if (new_start)
      pend_r <= 1'b0;
    else if (bit_cnt_r == BIT_LAST)
    begin
      unique case (st_r)
        ST_DEV:
        begin
          if (dev_ok && rx_sh_r[0])
            read_tgl_r <= ~read_tgl_r;
        end
        ST_WHI: waddr_r[ADDR_W-1:HI_LSB] <= rx_sh_r[HI_W-1:0]; // see R21
        ST_WLO:
        begin
          waddr_r[HI_LSB-1:0] <= rx_sh_r; // see R22
          addr_tgl_r <= ~addr_tgl_r;
        end
        ST_WDATA:
        begin
          wdata_r <= rx_sh_r;
          data_tgl_r <= ~data_tgl_r;
          pend_r <= 1'b1;
        end
        ST_IDLE, ST_READ: ;
      endcase
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Core clock domain

  logic [EV_W-1:0] evt_s;
  logic [EV_W-1:0] evt_prev_r;
  logic [EV_W-1:0] evt_edge;
  logic [WR_CNT_W-1:0] wr_cnt_r;
  logic in_frame_r;
  logic [ADDR_W-1:0] word_addr_r;
  logic [7:0] wr_data_r;
  logic addr_valid_r;
  logic wr_data_valid_r;
  logic read_start_r;
  logic standby_r;

  sync3 #(.W(EV_W)) u_sync_core
  (
    .clk(clk),
    .rst(rst),
    .d({start_tgl, stop_tgl, addr_tgl_r, data_tgl_r, read_tgl_r, pend_r}),
    .q(evt_s)
  );

  assign evt_edge = evt_s ^ evt_prev_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      evt_prev_r <= '0;
    else
      evt_prev_r <= evt_s;
  end

  // Words are copied after their toggle settles; the source holds them a byte
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      word_addr_r <= '0;
      wr_data_r <= 8'h00;
      addr_valid_r <= 1'b0;
      wr_data_valid_r <= 1'b0;
      read_start_r <= 1'b0;
    end
    else
    begin
      addr_valid_r <= evt_edge[EV_ADDR];
      wr_data_valid_r <= evt_edge[EV_DATA];
      read_start_r <= evt_edge[EV_READ];
      if (evt_edge[EV_ADDR])
        word_addr_r <= waddr_r;
      if (evt_edge[EV_DATA])
        wr_data_r <= wdata_r;
    end
  end

  // Internal write cycle timer, launched by a stop after written data
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_r <= 1'b0;
      wr_cnt_r <= '0;
    end
    else if (busy_r)
    begin
      if (wr_cnt_r == '0)
        busy_r <= 1'b0; // see R13
      else
        wr_cnt_r <= wr_cnt_r - 1'b1;
    end
    else if (evt_edge[EV_STOP] && evt_s[EV_PEND])
    begin
      busy_r <= 1'b1; // see R12
      wr_cnt_r <= WR_CNT_W'(WR_CYCLES - 1);
    end
  end

  // Frame tracking: between a stop and a start both lines rest high
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      in_frame_r <= 1'b0;
    else if (evt_edge[EV_START])
      in_frame_r <= 1'b1;
    else if (evt_edge[EV_STOP])
      in_frame_r <= 1'b0; // see R6, R14
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      standby_r <= 1'b1;
    else
      standby_r <= !busy_r && !in_frame_r && !evt_edge[EV_START]; // see R12, R13
  end

  assign word_addr = word_addr_r;
  assign page_idx = word_addr_r[ADDR_W-1:BYTE_W]; // see R23
  assign byte_idx = word_addr_r[BYTE_W-1:0]; // see R23
  assign addr_valid = addr_valid_r;
  assign wr_data = wr_data_r;
  assign wr_data_valid = wr_data_valid_r;
  assign read_start = read_start_r;
  assign write_busy = busy_r;
  assign standby = standby_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_bit_range: assert property (@(negedge scl_clk) disable iff (rst) // see R2
    bit_cnt_r <= BIT_ACK) else $error("bit counter beyond ack slot");

  a_idle_quiet: assert property (@(negedge scl_clk) disable iff (rst) // see R7
    (st_r == ST_IDLE && !new_start) |=> !sda_oe_r [*2]) else $error("drive while idle");

  a_dev_ack: assert property (@(negedge scl_clk) disable iff (rst) // see R19
    (st_r == ST_DEV && bit_cnt_r == BIT_LAST && !new_start && dev_ok)
    |=> (sda_oe_r && bit_cnt_r == BIT_ACK) ##1 (st_r == ST_READ || !sda_oe_r))
    else $error("matching address not acked");

  a_dev_nack: assert property (@(negedge scl_clk) disable iff (rst) // see R16
    (st_r == ST_DEV && bit_cnt_r == BIT_LAST && !new_start && !addr_match(rx_sh_r, pins_s))
    |=> (!sda_oe_r && st_r == ST_IDLE)) else $error("mismatched address acked");

  a_busy_nack: assert property (@(negedge scl_clk) disable iff (rst) // see R24
    (st_r == ST_DEV && bit_cnt_r == BIT_LAST && !new_start && busy_s)
    |=> !sda_oe_r) else $error("address acked during write cycle");

  a_rw_dir: assert property (@(negedge scl_clk) disable iff (rst) // see R18
    (st_r == ST_DEV && bit_cnt_r == BIT_LAST && !new_start && dev_ok)
    |=> ((st_r == ST_READ) == $past(rx_sh_r[0]))) else $error("direction bit misread");

  a_hi_capture: assert property (@(negedge scl_clk) disable iff (rst) // see R21
    (st_r == ST_WHI && bit_cnt_r == BIT_LAST && !new_start)
    |=> (waddr_r[ADDR_W-1:HI_LSB] == $past(rx_sh_r[HI_W-1:0]) && sda_oe_r))
    else $error("high word address not taken");

  a_lo_capture: assert property (@(negedge scl_clk) disable iff (rst) // see R22
    (st_r == ST_WLO && bit_cnt_r == BIT_LAST && !new_start)
    |=> (waddr_r[HI_LSB-1:0] == $past(rx_sh_r) && sda_oe_r && st_r == ST_WDATA))
    else $error("low word address not taken");

  a_tx_release: assert property (@(negedge scl_clk) disable iff (rst) // see R9
    (st_r == ST_READ && bit_cnt_r == BIT_LAST && !new_start) |=> !sda_oe_r)
    else $error("transmitter holds line in ack slot");

  a_nack_release: assert property (@(negedge scl_clk) disable iff (rst) // see R10
    (st_r == ST_READ && bit_cnt_r == BIT_ACK && host_nack_r && !new_start)
    |=> (!sda_oe_r && st_r == ST_IDLE)) else $error("line held after host nack");

  a_stop_idle: assert property (@(negedge scl_clk) disable iff (rst) // see R6
    (new_stop && !new_start) |=> (st_r == ST_IDLE && !sda_oe_r))
    else $error("sequence kept after stop");

  a_wr_launch: assert property (@(posedge clk) disable iff (rst) // see R12
    (!busy_r && evt_edge[EV_STOP] && evt_s[EV_PEND]) |=> (busy_r && !standby_r) [*2])
    else $error("write cycle not launched by stop");

  a_wr_done: assert property (@(posedge clk) disable iff (rst) // see R13
    (busy_r && wr_cnt_r == '0 && !in_frame_r && !evt_edge[EV_START])
    |=> ##1 standby_r) else $error("no standby after write cycle");

endmodule : eeprom_two_wire_client_front_end

/* File: two_wire_host_model.sv */
// Behavioural two-wire bus host: owns the serial clock and pulls the data line low.
// Assumes an external pull-up, so a released data line reads high.
`timescale 1ns/1ps
module two_wire_host_model
(
  output logic scl,
  output logic pull_low,
  input wire logic sda,
  output int glitches
);
  // Quarter of the 64 ns serial clock period
  localparam int Q = 16;

  initial
  begin
    scl = 1'b1;
    pull_low = 1'b0;
    glitches = 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock stands high between frames; it only runs inside these tasks
  task automatic start_cond();
    #Q pull_low = 1'b0;
    #Q scl = 1'b1;
    #Q pull_low = 1'b1;
    #Q scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #Q pull_low = 1'b1;
    #Q scl = 1'b1;
    #Q pull_low = 1'b0;
  endtask : stop_cond

  // Data moves mid-low; sampled twice while high to catch late changes
  task automatic clk_bit(input logic drv, output logic got);
    logic first;
    #Q pull_low = ~drv;
    #Q scl = 1'b1;
    #(Q / 2) first = sda;
    #Q got = sda;
    if (got !== first) glitches++;
    #(Q / 2) scl = 1'b0;
  endtask : clk_bit

  task automatic write_byte(input logic [7:0] v, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) clk_bit(v[i], g);
    pull_low = 1'b0;
    clk_bit(1'b1, g);
    ack = ~g;
  endtask : write_byte

  task automatic read_byte(input logic nack, output logic [7:0] v);
    logic g;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, v[i]);
    clk_bit(nack, g);
    pull_low = 1'b0;
  endtask : read_byte
endmodule : two_wire_host_model

/* File: testbench.sv */
// Self-checking bench for the two-wire client front end.
// Assumes the host model owns the serial clock and a pull-up resolves the data line.
`timescale 1ns/1ps
module testbench
  import eeprom_fe_pkg::*;
;
  // Short write cycle keeps the run brief
  localparam int WR = 60;
  logic clk, rst, host_pull, sda_o, sda_oe, ack, g, scl;
  logic [2:0] pins;
  logic [7:0] rd_byte, b, hi, lo, d, r, wr_data, cap_wd;
  logic [ADDR_W-1:0] word_addr, cap_addr;
  logic [PAGE_W-1:0] page_idx, cap_page;
  logic [BYTE_W-1:0] byte_idx, cap_byte;
  logic addr_valid, wr_data_valid, read_start, write_busy, standby;
  int mismatches, check_count, cyc, n_read, exp_reads, busy_len, glitches, i, n, seed;
  wire sda_line = ~(host_pull | (sda_oe & ~sda_o));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  two_wire_host_model host (.scl(scl), .pull_low(host_pull), .sda(sda_line),
    .glitches(glitches));

  eeprom_two_wire_client_front_end #(.WR_CYCLES(WR)) uut (.clk(clk), .rst(rst),
    .scl_clk(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .client_select_pin_0(pins[0]), .client_select_pin_1(pins[1]),
    .client_select_pin_2(pins[2]), .rd_byte(rd_byte), .word_addr(word_addr),
    .page_idx(page_idx), .byte_idx(byte_idx), .addr_valid(addr_valid),
    .wr_data(wr_data), .wr_data_valid(wr_data_valid), .read_start(read_start),
    .write_busy(write_busy), .standby(standby));

  ////////////////////////////////////////////////////////////////////////////////
  // Pulses are one clock wide, so capture them as they pass
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    busy_len <= busy_len + int'(write_busy);
    if (read_start) n_read <= n_read + 1;
    if (addr_valid)
    begin
      cap_addr <= word_addr;
      cap_page <= page_idx;
      cap_byte <= byte_idx;
    end
    if (wr_data_valid) cap_wd <= wr_data;
  end

  function automatic logic exp_ack(input logic [7:0] v, input logic [2:0] p);
    return (v[7:4] == TYPE_CODE) && (v[3:1] == p);
  endfunction : exp_ack

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input logic [7:0] v, input logic e);
    host.write_byte(v, ack);
    check(ack, e);
  endtask : send

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  initial
  begin
    wait (cyc == 20000);
    mismatches++;
    $display("[FAIL] t=%0t timeout", $time);
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    pins = 3'h0;
    rd_byte = 8'h00;
    seed = $urandom(67129);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(standby, 1'b1);
    send({TYPE_CODE, pins, 1'b0}, 1'b0);
    $display("test no_start done");
    for (i = 0; i < 12; i++)
    begin
      @(posedge clk);
      pins <= 3'($urandom);
      rd_byte <= 8'($urandom);
      @(posedge clk);
      b = 8'($urandom);
      if (i % 3 == 0) b[7:1] = {TYPE_CODE, pins};
      if (i == 1) b[7:1] = {4'hb, pins};
      host.start_cond();
      send(b, exp_ack(b, pins));
      if (exp_ack(b, pins) && b[0])
      begin
        exp_reads++;
        host.read_byte(1'b1, r);
        check(r, rd_byte);
      end
      host.stop_cond();
      repeat (8) @(posedge clk);
      check(standby, 1'b1);
    end
    $display("test address_match done");
    hi = 8'($urandom);
    lo = 8'($urandom);
    d = 8'($urandom);
    b = {TYPE_CODE, pins, 1'b0};
    host.start_cond();
    send(b, 1'b1);
    send(hi, 1'b1);
    send(lo, 1'b1);
    repeat (10) @(posedge clk);
    check(cap_addr, {hi[4:0], lo});
    check(cap_page, {hi[4:0], lo[7:5]});
    check(cap_byte, lo[4:0]);
    send(d, 1'b1);
    repeat (10) @(posedge clk);
    check(cap_wd, d);
    host.stop_cond();
    repeat (8) @(posedge clk);
    check({write_busy, standby}, 2'b10);
    host.start_cond();
    send(b, 1'b0);
    host.stop_cond();
    for (n = 0; n < 200 && write_busy; n++) @(posedge clk);
    repeat (4) @(posedge clk);
    check(standby, 1'b1);
    check(16'(busy_len), 16'(WR));
    $display("test write_cycle done");
    lo = ~lo;
    host.start_cond();
    send(b, 1'b1);
    send(hi, 1'b1);
    send(lo, 1'b1);
    send(d, 1'b1);
    host.start_cond();
    send(b | 8'h01, 1'b1);
    exp_reads++;
    host.read_byte(1'b0, r);
    check(r, rd_byte);
    host.read_byte(1'b1, r);
    check(r, rd_byte);
    @(posedge clk);
    check(sda_oe, 1'b0);
    host.stop_cond();
    repeat (10) @(posedge clk);
    check(write_busy, 1'b0);
    check(cap_addr, {hi[4:0], lo});
    $display("test repeated_start done");
    @(posedge clk);
    rd_byte <= 8'h00;
    @(posedge clk);
    host.start_cond();
    send(b | 8'h01, 1'b1);
    exp_reads++;
    for (n = 0; n < 3; n++) host.clk_bit(1'b1, g);
    g = 1'b0;
    for (n = 0; n < 9 && !g; n++) host.clk_bit(1'b1, g);
    check(g, 1'b1);
    host.start_cond();
    host.stop_cond();
    send({TYPE_CODE, pins, 1'b0}, 1'b0);
    repeat (8) @(posedge clk);
    check(standby, 1'b1);
    check(16'(n_read), 16'(exp_reads));
    check(16'(glitches), 16'h0000);
    $display("test recovery done");
    give_verdict();
  end
endmodule : testbench
